// ===== hw/bcs_host.sv
// Purpose: host controller that captures and reads a chain of byte-scan counters
// Assumes: counter pins driven by this block; byte bus sampled via two flops
// Notes: one capture reads num_dev devices, four bytes each, into the fifo
`timescale 1ns/1ps
// Contract
// - hold load low at least 1 us and until 4 us after count edge.
// - return load high at least 250 ns before next count edge or reset.
// - change enable only while the scan strobe is low.
// - chain-pass feeds next enable; strobe and load lines are shared.
module bcs_host import bcs_pkg::*; (
    input wire logic core_clk,                // system clock, 250 MHz
    input wire logic reset,                   // synchronous reset, active high
    input wire logic clear_req,               // pulse: clear the counters
    input wire logic capture_req,             // pulse: capture and read the chain
    input wire logic [DEV_W-1:0] num_dev,     // devices in cascade, 0..7
    input wire logic count_in,                // event source to count
    input wire logic test_count_in,           // test events for upper half
    output logic busy,                        // operation in progress
    output logic count_pin,                   // to device main count input
    output logic test_count_pin,              // to device test count input
    output logic reset_n_pin,                 // to device counter reset
    output logic scan_rst_load_n_pin,         // to device scan reset and load
    output logic scan_pin,                    // to device scan strobe
    output logic enable_n_pin,                // to first device enable
    input wire logic [BYTE_W-1:0] byte_bus_outputs, // shared readout bus
    output logic [BYTE_W-1:0] rd_data,        // captured byte, lsb first
    output logic rd_valid,                    // byte available
    input wire logic rd_ready                 // consumer takes byte
);
    bcs_reg_t s_r, s_nxt;
    logic [BYTE_W-1:0] bus_m_r, bus_s_r;
    logic fifo_in_ready;

    // two-flop synchroniser for the external byte bus
    always_ff @(posedge core_clk) begin
        bus_m_r <= byte_bus_outputs;
        bus_s_r <= bus_m_r;
    end

    function automatic logic [TMR_W-1:0] cyc(input int n);
        return TMR_W'(n);
    endfunction

    // main sequencer
    always_comb begin
        s_nxt = s_r;
        s_nxt.tmr = (s_r.tmr != '0) ? s_r.tmr - 1'b1 : s_r.tmr;
        // count pins follow the local sources; track falling count edges
        s_nxt.pins.count_pin = count_in;
        s_nxt.pins.test_count_pin = test_count_in;
        if (s_r.pins.count_pin && !count_in) begin
            s_nxt.since_cnt = '0;
        end else if (s_r.since_cnt != cyc(RIPPLE_CYC)) begin
            s_nxt.since_cnt = s_r.since_cnt + 1'b1;
        end
        if (s_r.push && fifo_in_ready) begin
            s_nxt.push = 1'b0;
        end
        case (s_r.st)
            ST_IDLE: begin
                s_nxt.busy = 1'b0;
                if (clear_req) begin
                    s_nxt.pins.reset_n = 1'b0;
                    s_nxt.tmr = cyc(RESET_LOW_CYC);
                    s_nxt.busy = 1'b1;
                    s_nxt.st = ST_RST_LOW;
                end else if (capture_req) begin
                    s_nxt.busy = 1'b1;
                    s_nxt.st = ST_LOAD_WAIT;
                end
            end
            ST_RST_LOW: begin
                if (s_r.tmr == '0) begin
                    s_nxt.pins.reset_n = 1'b1;
                    s_nxt.tmr = cyc(RESET_RECOVER_CYC);
                    s_nxt.st = ST_RST_REC;
                end
            end
            ST_RST_REC: begin
                if (s_r.tmr == '0) begin
                    s_nxt.st = ST_IDLE;
                end
            end
            ST_LOAD_WAIT: begin
                // strobe and enable go low on the same edge as the load pulse
                s_nxt.pins.scan = 1'b0;
                s_nxt.pins.enable_n = 1'b0;
                s_nxt.pins.scan_rst_load_n = 1'b0;
                s_nxt.tmr = cyc(LOAD_LOW_CYC);
                s_nxt.st = ST_LOAD_LOW;
            end
            ST_LOAD_LOW: begin
                // release only after the pulse width and ripple settle
                if (s_r.tmr == '0 && s_r.since_cnt == cyc(RIPPLE_CYC)) begin
                    s_nxt.pins.scan_rst_load_n = 1'b1;
                    s_nxt.tmr = cyc(LOAD_RECOVER_CYC);
                    s_nxt.st = ST_LOAD_REC;
                end
            end
            ST_LOAD_REC: begin
                // a count edge this close may spoil the snapshot; redo it
                if (s_r.pins.count_pin && !count_in) begin
                    s_nxt.st = ST_LOAD_WAIT;
                end else if (s_r.tmr == '0) begin
                    s_nxt.left = {1'b0, num_dev, 2'b00};
                    s_nxt.tmr = cyc(SCAN_PULSE_CYC);
                    s_nxt.st = ST_SCAN_LOW;
                end
            end
            ST_SCAN_LOW: begin
                // wait for fifo room so a byte is never dropped
                if (s_r.left == '0) begin
                    s_nxt.st = ST_IDLE;
                end else if (s_r.tmr == '0 && !s_r.push) begin
                    s_nxt.pins.scan = 1'b1;
                    s_nxt.tmr = cyc(SCAN_PULSE_CYC);
                    s_nxt.st = ST_SCAN_HIGH;
                end
            end
            ST_SCAN_HIGH: begin
                // bus settles well inside the high time; sample at its end
                if (s_r.tmr == '0) begin
                    s_nxt.data = bus_s_r;
                    s_nxt.push = 1'b1;
                    s_nxt.pins.scan = 1'b0;
                    s_nxt.tmr = cyc(SCAN_PULSE_CYC);
                    s_nxt.st = ST_SCAN_FALL;
                end
            end
            ST_SCAN_FALL: begin
                s_nxt.left = s_r.left - 1'b1;
                s_nxt.st = ST_SCAN_LOW;
            end
            default: begin
                s_nxt.st = ST_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge core_clk) begin
        if (reset) begin
            s_r.st <= ST_IDLE;
            s_r.pins <= '{count_pin: 1'b0, test_count_pin: 1'b0, reset_n: 1'b1,
                          scan_rst_load_n: 1'b1, scan: 1'b0, enable_n: 1'b1};
            s_r.tmr <= '0;
            s_r.since_cnt <= '0;
            s_r.left <= '0;
            s_r.data <= '0;
            s_r.push <= 1'b0;
            s_r.busy <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign busy = s_r.busy;
    assign count_pin = s_r.pins.count_pin;
    assign test_count_pin = s_r.pins.test_count_pin;
    assign reset_n_pin = s_r.pins.reset_n;
    assign scan_rst_load_n_pin = s_r.pins.scan_rst_load_n;
    assign scan_pin = s_r.pins.scan;
    assign enable_n_pin = s_r.pins.enable_n;

    bcs_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .core_clk(core_clk),
        .reset(reset),
        .in_data(s_r.data),
        .in_valid(s_r.push),
        .in_ready(fifo_in_ready),
        .out_data(rd_data),
        .out_valid(rd_valid),
        .out_ready(rd_ready)
    );

    // load pulse is never shorter than the least width
    logic [TMR_W-1:0] low_run_r;
    always_ff @(posedge core_clk) begin
        if (reset || scan_rst_load_n_pin) begin
            low_run_r <= '0;
        end else if (low_run_r != {TMR_W{1'b1}}) begin
            low_run_r <= low_run_r + 1'b1;
        end
    end
    load_width_a: assert property (@(posedge core_clk) disable iff (reset)
        $rose(scan_rst_load_n_pin) |-> $past(low_run_r) >= cyc(LOAD_LOW_CYC - 1))
        else $error("load pulse shorter than least width");
    enable_quiet_a: assert property (@(posedge core_clk) disable iff (reset)
        $changed(enable_n_pin) |-> !scan_pin && !$past(scan_pin))
        else $error("enable changed while strobe high");
    scan_width_a: assert property (@(posedge core_clk) disable iff (reset)
        $rose(scan_pin) |=> scan_pin [*8])
        else $error("strobe high too short");
    reset_width_a: assert property (@(posedge core_clk) disable iff (reset)
        $fell(reset_n_pin) |=> !reset_n_pin [*8])
        else $error("counter reset too short");
    load_before_scan_a: assert property (@(posedge core_clk) disable iff (reset)
        $rose(scan_pin) |-> scan_rst_load_n_pin)
        else $error("strobe during load");
    push_hold_a: assert property (@(posedge core_clk) disable iff (reset)
        s_r.push && !fifo_in_ready |=> s_r.push && $stable(s_r.data))
        else $error("byte lost under back-pressure");
    ripple_wait_a: assert property (@(posedge core_clk) disable iff (reset)
        $rose(scan_rst_load_n_pin) |-> $past(s_r.since_cnt) == cyc(RIPPLE_CYC))
        else $error("load released before ripple settled");
    idle_pins_a: assert property (@(posedge core_clk) disable iff (reset)
        !busy && !$past(busy) |-> !scan_pin && scan_rst_load_n_pin)
        else $error("strobe or load active while idle");

    // strobe low run before each rise; a short low phase can miss a step
    logic [TMR_W-1:0] scan_low_r;
    always_ff @(posedge core_clk) begin
        if (reset || scan_pin) begin
            scan_low_r <= '0;
        end else if (scan_low_r != {TMR_W{1'b1}}) begin
            scan_low_r <= scan_low_r + 1'b1;
        end
    end
    scan_low_a: assert property (@(posedge core_clk) disable iff (reset)
        $rose(scan_pin) |-> $past(scan_low_r) >= cyc(SCAN_PULSE_CYC - 1))
        else $error("strobe low too short");
endmodule // bcs_host

// ===== pkg/bcs_pkg.sv
// Purpose: shared constants and types for the byte-scan counter host controller
// Assumes: core_clk at 250 MHz (4 ns period)
// Notes: times are held in ns and converted to cycle counts here
package bcs_pkg;
    localparam int CLK_PERIOD_NS = 4;
    // pulse and settle times in ns
    localparam int LOAD_LOW_NS = 1000;      // least low time of scan-reset/load
    localparam int RIPPLE_NS = 4000;        // ripple settle after count edge
    localparam int LOAD_RECOVER_NS = 250;   // load high before next count edge
    localparam int SCAN_PULSE_NS = 500;     // least scan high and low width
    localparam int RESET_LOW_NS = 1000;     // least counter reset low time
    localparam int RESET_RECOVER_NS = 300;  // reset high before next count
    // least times round up
    localparam int LOAD_LOW_CYC = (LOAD_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RIPPLE_CYC = (RIPPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LOAD_RECOVER_CYC = (LOAD_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SCAN_PULSE_CYC = (SCAN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_LOW_CYC = (RESET_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_RECOVER_CYC = (RESET_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TMR_W = 12;
    localparam int BYTES_PER_DEV = 4;       // scan states 1..4 carry data
    localparam int DEV_W = 3;               // cascade length field width
    localparam int FIFO_DEPTH = 16;
    localparam int BYTE_W = 8;
    localparam logic [31:0] COUNT_ZERO = 32'h0000_0000;

    // pins toward the counter chain
    typedef struct packed {
        logic count_pin;        // main count input, falling edge counts
        logic test_count_pin;   // upper-half test count input
        logic reset_n;          // counter reset, active low
        logic scan_rst_load_n;  // scan reset and latch load, active low
        logic scan;             // scan strobe
        logic enable_n;         // first device enable, active low
    } bcs_pins_t;

    typedef enum {
        ST_IDLE, ST_RST_LOW, ST_RST_REC, ST_LOAD_WAIT, ST_LOAD_LOW, ST_LOAD_REC,
        ST_SCAN_LOW, ST_SCAN_HIGH, ST_SCAN_FALL
    } bcs_state_t;

    typedef struct packed {
        bcs_state_t st;
        bcs_pins_t pins;
        logic [TMR_W-1:0] tmr;       // general wait counter
        logic [TMR_W-1:0] since_cnt; // cycles since last falling count edge
        logic [DEV_W+2:0] left;      // strobes still to issue
        logic [BYTE_W-1:0] data;     // last captured byte
        logic push;                  // byte waiting to enter fifo
        logic busy;
    } bcs_reg_t;
endpackage

// ===== hw/bcs_fifo.sv
// Purpose: synchronous valid/ready fifo for captured bytes
// Assumes: single clock, synchronous active-high reset
// Notes: full and empty come straight from the occupancy count
`timescale 1ns/1ps
module bcs_fifo import bcs_pkg::*; #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic core_clk,            // system clock
    input wire logic reset,               // synchronous reset
    input wire logic [WIDTH-1:0] in_data, // write data
    input wire logic in_valid,            // write request
    output logic in_ready,                // space available
    output logic [WIDTH-1:0] out_data,    // read data
    output logic out_valid,               // data available
    input wire logic out_ready            // reader takes data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } bcs_fifo_st_t;
    bcs_fifo_st_t s_r, s_nxt;
    logic wr, rd;

    // handshakes are combinational from the count
    assign in_ready = (s_r.cnt != (AW+1)'(DEPTH));
    assign out_valid = (s_r.cnt != '0);
    assign out_data = mem[s_r.rp];
    assign wr = in_valid && in_ready;
    assign rd = out_valid && out_ready;

    // pointer and count update
    always_comb begin
        s_nxt = s_r;
        if (wr) begin
            s_nxt.wp = s_r.wp + 1'b1;
        end
        if (rd) begin
            s_nxt.rp = s_r.rp + 1'b1;
        end
        s_nxt.cnt = s_r.cnt + (AW+1)'(wr) - (AW+1)'(rd);
    end

    // storage has no reset; only pointers and count need a defined value
    always_ff @(posedge core_clk) begin
        if (reset) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
        if (wr) begin
            mem[s_r.wp] <= in_data;
        end
    end
endmodule // bcs_fifo

// ===== tb/bcs_dev_model.sv
// Purpose: behavioural model of one byte-scan binary counter on the shared readout bus
// Assumes: pins come from the host controller; the device has no clock of its own
// Notes: viol goes high and stays high once the host breaks a pin timing limit
`timescale 1ns/1ps
module bcs_dev_model (
    input wire logic count_pin,       // main count, falling edge counts
    input wire logic test_count_pin,  // upper-half test count
    input wire logic reset_n,         // counter clear, active low
    input wire logic scan_rst_load_n, // scan reset and latch load, active low
    input wire logic scan,            // scan strobe
    input wire logic enable_n,        // device enable, active low
    output logic cascade_n,           // chain pass toward the next enable
    output logic oe,                  // bus drivers on
    output logic [7:0] dout,          // byte offered to the bus
    output logic viol                 // host timing fault seen
);
    logic [31:0] cnt = 32'h0;
    logic [31:0] lat = 32'h0;
    logic casc = 1'b1;
    int st = 1;
    realtime t_cnt = 0.0;
    realtime t_fall = 0.0;
    realtime t_rise = -1.0e6;
    initial viol = 1'b0;
    // clear wins over counting; a count or clear too soon after load release spoils the snapshot
    always @(negedge count_pin or negedge reset_n) begin
        // edges from the unknown start-up level come before any load and are no host fault
        if (t_fall > 0.0 && $realtime - t_rise < 250.0) viol = 1'b1;
        if (!reset_n) begin
            cnt = 32'h0;
        end else begin
            cnt = cnt + 32'h1;
            t_cnt = $realtime;
        end
    end
    // index 15 is the sixteenth bit, the carry into the upper half
    always @(negedge test_count_pin) begin
        if (reset_n && !cnt[15]) cnt[31:16] = cnt[31:16] + 16'h1;
    end
    always @(negedge scan_rst_load_n) begin
        st = 1;
        t_fall = $realtime;
    end
    // latches take the count at the load release and keep it from then on
    always @(posedge scan_rst_load_n) begin
        lat = cnt;
        casc = 1'b1;
        t_rise = $realtime;
        if (t_fall > 0.0 && ($realtime - t_fall < 1000.0 || $realtime - t_cnt < 4000.0)) viol = 1'b1;
    end
    // strobes step only while enabled and short of the terminal state
    always @(negedge scan) begin
        if (enable_n === 1'b0 && scan_rst_load_n && st < 5) st = st + 1;
        if (st == 5) casc = 1'b0;
    end
    always @(enable_n) begin
        if (scan === 1'b1) viol = 1'b1;
    end
    // output delay keeps the next device from stepping on the very edge that enables it
    assign #1 cascade_n = casc;
    assign oe = !enable_n && scan && st < 5;
    assign dout = lat[8*(st-1) +: 8];
endmodule // bcs_dev_model

// ===== tb/binary_counter_byte_scan_mux_bench.sv
// Purpose: self-checking bench for the byte-scan counter host with two chained devices
// Assumes: seed 65; devices modelled behaviourally on the host pins
// Notes: an undriven bus shows the inverse of its last value so stale bytes never match
`timescale 1ns/1ps
module binary_counter_byte_scan_mux_bench;
    import bcs_pkg::*;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic clear_req = 1'b0, capture_req = 1'b0, count_in = 1'b0, test_count_in = 1'b0, rd_ready = 1'b0;
    logic [DEV_W-1:0] num_dev = 3'h1;
    logic busy, count_pin, test_count_pin, reset_n_pin, scan_rst_load_n_pin, scan_pin, enable_n_pin, rd_valid;
    logic [7:0] byte_bus_outputs, last_bus = 8'h00, rd_data, dout0, dout1;
    logic casc0, casc1, oe0, oe1, viol0, viol1, stall = 1'b0;
    logic [31:0] exp_cnt = 32'h0;
    logic [7:0] got_q[$], exp_q[$];
    int n_fail = 0, compares = 0, cyc = 0;
    always #2 core_clk = ~core_clk;
    bcs_host i_dut (.core_clk, .reset, .clear_req, .capture_req, .num_dev, .count_in, .test_count_in, .busy,
        .count_pin, .test_count_pin, .reset_n_pin, .scan_rst_load_n_pin, .scan_pin, .enable_n_pin,
        .byte_bus_outputs, .rd_data, .rd_valid, .rd_ready);
    bcs_dev_model i_dev0 (.count_pin, .test_count_pin, .reset_n(reset_n_pin), .scan_rst_load_n(scan_rst_load_n_pin),
        .scan(scan_pin), .enable_n(enable_n_pin), .cascade_n(casc0), .oe(oe0), .dout(dout0), .viol(viol0));
    bcs_dev_model i_dev1 (.count_pin, .test_count_pin, .reset_n(reset_n_pin), .scan_rst_load_n(scan_rst_load_n_pin),
        .scan(scan_pin), .enable_n(casc0), .cascade_n(casc1), .oe(oe1), .dout(dout1), .viol(viol1));
    assign byte_bus_outputs = oe0 === 1'b1 ? dout0 : (oe1 === 1'b1 ? dout1 : ~last_bus);
    // collect bytes; the consumer stalls at random, or fully while stall is set
    always @(posedge core_clk) begin
        last_bus <= byte_bus_outputs;
        if (!reset && rd_valid === 1'b1 && rd_ready) got_q.push_back(rd_data);
        rd_ready <= !stall && ($urandom % 4 != 0);
        cyc++;
        if (cyc == 90000) begin
            n_fail++;
            summarize();
        end
    end
    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic summarize();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // expected counter after one count edge of either kind
    function automatic logic [31:0] next_cnt(logic [31:0] c, bit test);
        if (!test) return c + 32'h1;
        return c[15] ? c : {c[31:16] + 16'h1, c[15:0]};
    endfunction
    // pulses wide enough for the device count input
    task automatic pulses(bit test, int n);
        for (int i = 0; i < n; i++) begin
            count_in <= !test;
            test_count_in <= test;
            repeat (10) @(posedge core_clk);
            count_in <= 1'b0;
            test_count_in <= 1'b0;
            repeat (10) @(posedge core_clk);
            exp_cnt = next_cnt(exp_cnt, test);
        end
    endtask
    task automatic wait_idle();
        int k;
        k = 0;
        @(posedge core_clk);
        while (busy !== 1'b0 && k < 20000) begin
            @(posedge core_clk);
            k++;
        end
        check("busy", 0, busy);
    endtask
    task automatic request(bit clr);
        @(posedge core_clk);
        clear_req <= clr;
        capture_req <= !clr;
        @(posedge core_clk);
        clear_req <= 1'b0;
        capture_req <= 1'b0;
    endtask
    task automatic capture(logic [DEV_W-1:0] nd, bit refuse, bit wait_done);
        num_dev <= nd;
        request(1'b0);
        for (int d = 0; d < nd; d++) begin
            for (int i = 0; i < 4; i++) exp_q.push_back(exp_cnt[8*i +: 8]);
        end
        if (refuse) begin
            repeat (50) @(posedge core_clk);
            request(1'b0);
        end
        if (wait_done) wait_idle();
    endtask
    task automatic drain();
        int k;
        k = 0;
        while (got_q.size() < exp_q.size() && k < 8000) begin
            @(posedge core_clk);
            k++;
        end
        repeat (300) @(posedge core_clk);
        check("byte count", exp_q.size(), got_q.size());
        foreach (exp_q[i]) if (i < got_q.size()) check("byte", exp_q[i], got_q[i]);
        got_q.delete();
        exp_q.delete();
    endtask
    initial begin
        void'($urandom(65));
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        check("chain rest", 1, casc0);
        for (int it = 0; it < 4; it++) begin
            if (it != 1) begin
                request(1'b1);
                wait_idle();
                exp_cnt = 32'h0;
            end
            pulses(1'b1, $urandom % 20);
            pulses(1'b0, 1 + $urandom % 100);
            capture(DEV_W'(1 + it % 2), it == 1, 1'b1);
            check("chain0", 0, casc0);
            check("chain1", it % 2 == 1 ? 0 : 1, casc1);
            drain();
        end
        // an empty chain read still pulses load, which lifts both chain outputs again
        capture(3'h0, 1'b0, 1'b1);
        check("chain0 lifted", 1, casc0);
        check("chain1 lifted", 1, casc1);
        drain();
        // fill the fifo, then a third capture must stall on it
        stall <= 1'b1;
        capture(3'h2, 1'b0, 1'b1);
        capture(3'h2, 1'b0, 1'b1);
        capture(3'h1, 1'b0, 1'b0);
        repeat (3000) @(posedge core_clk);
        check("stalled busy", 1, busy);
        check("held valid", 1, rd_valid);
        stall <= 1'b0;
        wait_idle();
        drain();
        check("viol0", 0, viol0);
        check("viol1", 0, viol1);
        summarize();
    end
endmodule // binary_counter_byte_scan_mux_bench
